// File: rtl/ebbc_ctrl.sv
// Behaviour
// R1 - strap pins sampled in reset: nand boot, 16-bit, 32-bit or test mode
// R2 - strap levels captured only while reset is low, then frozen
// R3 - drive 27-bit address within the selected bank
// R4 - data bus reads in, writes out, width 8, 16 or 32 bits
// R5 - assert exactly one active-low bank select matching the address region
// R6 - per-bank access cycles and region size are programmable
// R7 - active-low write strobe marks a write cycle
// R8 - active-low read strobe marks a read cycle
// R9 - active-low hold request asks the device to give up the bus
// R10 - active-low hold grant once released; requester drives only while granted
// R11 - unchanged pins keep their pre-hold state during hold
// R12 - auxiliary control bit picks high impedance or previous state in hold
// R13 - cycle is not completed while cycle stretch input is low
// R14 - grant hold only between accesses with selects and strobes inactive
`timescale 1ns/1ps
`default_nettype none
module ebbc_ctrl
   import ebbc_pkg::*;
#(
   parameter int NBANK = BANKS
)
(
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic [1:0] BOOT_STRAP_PINS,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic REQ_WRITE,
   input wire logic [31:0] REQ_ADDR,
   input wire logic [DATA_W-1:0] REQ_WDATA,
   output logic [DATA_W-1:0] RSP_RDATA,
   output logic RSP_VALID,
   input wire logic [NBANK*WAIT_W-1:0] BANK_WAIT_CYCLES,
   input wire logic [NBANK*SIZE_W-1:0] BANK_SIZE_LOG2,
   input wire logic [NBANK*2-1:0] BANK_WIDTH,
   input wire logic AUXILIARY_CONTROL_HOLD_HIZ,
   output logic [1:0] BOOT_MODE,
   output logic BOOT_CAPTURED,
   output logic [ADDR_W-1:0] ADDR_OUT,
   output logic ADDR_OE,
   input wire logic [DATA_W-1:0] DATA_IN,
   output logic [DATA_W-1:0] DATA_OUT,
   output logic [DATA_W-1:0] DATA_OE,
   output logic [NBANK-1:0] BANK_SELECT_N,
   output logic WRITE_STROBE_N,
   output logic READ_STROBE_N,
   output logic CTRL_OE,
   input wire logic HOLD_REQUEST_N,
   output logic HOLD_GRANT_N,
   input wire logic CYCLE_STRETCH_N
);
   // pin synchronisers; first stage feeds only the second
   logic [1:0] strap_s1, strap_s2;
   logic req_s1, req_s2, wait_s1, wait_s2;
   always_ff @(posedge CLOCK)
   begin
      strap_s1 <= BOOT_STRAP_PINS;
      strap_s2 <= strap_s1;
      req_s1 <= HOLD_REQUEST_N;
      req_s2 <= req_s1;
      wait_s1 <= CYCLE_STRETCH_N;
      wait_s2 <= wait_s1;
   end

   // strap capture: follows pins during reset, frozen after release
   logic [1:0] boot_mode, next_boot_mode;
   logic boot_captured, next_boot_captured;
   always_comb
   begin
      next_boot_mode = boot_mode;
      next_boot_captured = boot_captured;
      if (!RST_B)
      begin
         next_boot_mode = strap_s2; // R1 R2
         next_boot_captured = 1'b0;
      end
      else
         next_boot_captured = 1'b1; // R2
   end
   always_ff @(posedge CLOCK)
   begin
      boot_mode <= next_boot_mode;
      boot_captured <= next_boot_captured;
   end
   assign BOOT_MODE = boot_mode;
   assign BOOT_CAPTURED = boot_captured;

   // bank decode: banks occupy consecutive 128 MB slots of the system address
   logic [2:0] bank_idx;
   logic [NBANK-1:0] bank_hit;
   logic [ADDR_W-1:0] bank_offs;
   assign bank_idx = REQ_ADDR[29:27];
   genvar g;
   generate
      for (g = 0; g < NBANK; g++)
      begin : g_bank
         logic [SIZE_W-1:0] sz;
         logic [ADDR_W-1:0] mask;
         assign sz = BANK_SIZE_LOG2[g*SIZE_W +: SIZE_W];
         assign mask = (sz >= 5'd27) ? {ADDR_W{1'b1}}
                     : ADDR_W'(({{(ADDR_W-1){1'b0}}, 1'b1} << sz) - 1'b1);
         // address beyond the programmed size falls outside the bank
         assign bank_hit[g] = (bank_idx == 3'(g)) && REQ_ADDR[31:30] == 2'h0
                            && ((REQ_ADDR[ADDR_W-1:0] & ~mask) == '0); // R5 R6
      end
   endgenerate
   assign bank_offs = REQ_ADDR[ADDR_W-1:0];

   // bank 0 width comes from strap; others from configuration
   logic [1:0] acc_width;
   always_comb
   begin
      acc_width = BANK_WIDTH[bank_idx*2 +: 2]; // R4
      if (bank_idx == 3'h0)
         acc_width = (boot_mode == BOOT_W16) ? WIDTH_16 : WIDTH_32;
   end

   // access sequencer
   ebbc_state_t state, next_state;
   logic [NBANK-1:0] sel_n, next_sel_n;
   logic we_n, next_we_n, oe_n, next_oe_n;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [DATA_W-1:0] wdata, next_wdata, wmask, next_wmask, rdata, next_rdata;
   logic [WAIT_W-1:0] cnt, next_cnt;
   logic rsp, next_rsp, grant_n, next_grant_n;
   logic [DATA_W-1:0] lanes;
   logic [DATA_W-1:0] lanes_q, next_lanes_q;
   always_comb
   begin
      unique case (acc_width)
         WIDTH_8: lanes = 32'h000000ff;
         WIDTH_16: lanes = 32'h0000ffff;
         default: lanes = 32'hffffffff;
      endcase
   end
   always_comb
   begin
      next_state = state;
      next_sel_n = sel_n;
      next_we_n = we_n;
      next_oe_n = oe_n;
      next_addr = addr;
      next_wdata = wdata;
      next_wmask = wmask;
      next_rdata = rdata;
      next_cnt = cnt;
      next_rsp = 1'b0;
      next_grant_n = grant_n;
      unique case (state)
         EBBC_IDLE:
         begin
            if (!req_s2) // R9
            begin
               next_state = EBBC_HOLD; // R14
               next_grant_n = 1'b0; // R10
            end
            else if (REQ_VALID && (|bank_hit))
            begin
               next_state = EBBC_ACCESS;
               next_sel_n = ~bank_hit; // R5
               next_addr = bank_offs; // R3
               next_we_n = ~REQ_WRITE; // R7
               next_oe_n = REQ_WRITE; // R8
               next_wdata = REQ_WDATA & lanes;
               next_wmask = REQ_WRITE ? lanes : '0; // R4
               next_cnt = BANK_WAIT_CYCLES[bank_idx*WAIT_W +: WAIT_W]; // R6
            end
            else if (REQ_VALID)
               next_rsp = 1'b1; // unmapped: answered at once, no pins move
         end
         EBBC_ACCESS:
         begin
            if (cnt != '0)
               next_cnt = cnt - 1'b1;
            else if (wait_s2) // R13
            begin
               next_state = EBBC_RECOVER;
               next_rdata = we_n ? (DATA_IN & (lanes_q)) : rdata; // R4
               next_sel_n = '1;
               next_we_n = 1'b1;
               next_oe_n = 1'b1;
               next_rsp = 1'b1;
            end
         end
         EBBC_RECOVER:
         begin
            next_state = EBBC_IDLE;
            next_wmask = '0;
         end
         EBBC_HOLD:
         begin
            if (req_s2)
            begin
               next_state = EBBC_IDLE;
               next_grant_n = 1'b1;
            end
         end
         default: next_state = EBBC_IDLE;
      endcase
   end
   // lane mask of the access in flight, for read capture
   assign next_lanes_q = (state == EBBC_IDLE) ? lanes : lanes_q;
   always_ff @(posedge CLOCK)
   begin
      if (!RST_B)
      begin
         state <= EBBC_IDLE;
         sel_n <= '1;
         we_n <= 1'b1;
         oe_n <= 1'b1;
         addr <= '0;
         wdata <= '0;
         wmask <= '0;
         rdata <= '0;
         cnt <= '0;
         rsp <= 1'b0;
         grant_n <= 1'b1;
         lanes_q <= '0;
      end
      else
      begin
         state <= next_state;
         sel_n <= next_sel_n;
         we_n <= next_we_n;
         oe_n <= next_oe_n;
         addr <= next_addr;
         wdata <= next_wdata;
         wmask <= next_wmask;
         rdata <= next_rdata;
         cnt <= next_cnt;
         rsp <= next_rsp;
         grant_n <= next_grant_n;
         lanes_q <= next_lanes_q;
      end
   end

   // pins hold last value in hold; address and control enables drop only if hi-z chosen, data enable drops in hold always
   logic hold;
   assign hold = (state == EBBC_HOLD);
   assign REQ_READY = (state == EBBC_IDLE) && req_s2;
   assign RSP_VALID = rsp;
   assign RSP_RDATA = rdata;
   assign ADDR_OUT = addr; // R11
   assign ADDR_OE = !(hold && AUXILIARY_CONTROL_HOLD_HIZ); // R12
   assign CTRL_OE = !(hold && AUXILIARY_CONTROL_HOLD_HIZ); // R12
   assign BANK_SELECT_N = sel_n; // R11
   assign WRITE_STROBE_N = we_n;
   assign READ_STROBE_N = oe_n;
   assign DATA_OUT = wdata;
   assign DATA_OE = hold ? '0 : wmask; // R10
   assign HOLD_GRANT_N = grant_n; // R10
endmodule
`default_nettype wire

// File: shared/ebbc_pkg.sv
package ebbc_pkg;
   // strap decode
   localparam logic [1:0] BOOT_NAND = 2'h0;
   localparam logic [1:0] BOOT_W16 = 2'h1;
   localparam logic [1:0] BOOT_W32 = 2'h2;
   localparam logic [1:0] BOOT_TEST = 2'h3;
   // data width codes
   localparam logic [1:0] WIDTH_8 = 2'h0;
   localparam logic [1:0] WIDTH_16 = 2'h1;
   localparam logic [1:0] WIDTH_32 = 2'h2;
   // bus geometry
   localparam int ADDR_W = 27;
   localparam int DATA_W = 32;
   localparam int BANKS = 8;
   localparam int WAIT_W = 4;
   localparam int SIZE_W = 5;
   // reset values
   localparam logic [WAIT_W-1:0] WAIT_RESET = 4'h1;
   localparam logic [SIZE_W-1:0] SIZE_RESET = 5'h1b;
   typedef enum logic [1:0] {EBBC_IDLE, EBBC_ACCESS, EBBC_RECOVER, EBBC_HOLD} ebbc_state_t;
endpackage

// File: verif/ebbc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ebbc_checker
   import ebbc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_B,
   input wire logic [1:0] BOOT_MODE,
   input wire logic [ADDR_W-1:0] ADDR_OUT,
   input wire logic ADDR_OE,
   input wire logic CTRL_OE,
   input wire logic [DATA_W-1:0] DATA_OE,
   input wire logic [BANKS-1:0] BANK_SELECT_N,
   input wire logic WRITE_STROBE_N,
   input wire logic READ_STROBE_N,
   input wire logic RSP_VALID,
   input wire logic REQ_READY,
   input wire logic HOLD_REQUEST_N,
   input wire logic HOLD_GRANT_N,
   input wire logic CYCLE_STRETCH_N,
   input wire logic AUXILIARY_CONTROL_HOLD_HIZ
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   // bus idle and a stretch long enough to pass the synchroniser
   sequence bus_quiet;
      &BANK_SELECT_N && WRITE_STROBE_N && READ_STROBE_N;
   endsequence
   sequence stretch_held;
      !CYCLE_STRETCH_N [*4];
   endsequence
   one_select_a: assert property ($onehot0(~BANK_SELECT_N))
      else $error("several selects low");
   strobe_excl_a: assert property (WRITE_STROBE_N || READ_STROBE_N)
      else $error("both strobes low");
   grant_quiet_a: assert property ($fell(HOLD_GRANT_N) |-> bus_quiet)
      else $error("grant during access");
   grant_cause_a: assert property ($fell(HOLD_GRANT_N) |-> !$past(HOLD_REQUEST_N, 2))
      else $error("grant without request");
   hold_busy_a: assert property (!HOLD_GRANT_N |-> (!REQ_READY and bus_quiet))
      else $error("bus used while granted");
   hold_hiz_a: assert property (!HOLD_GRANT_N && AUXILIARY_CONTROL_HOLD_HIZ
      |-> !ADDR_OE && !CTRL_OE && DATA_OE == '0)
      else $error("pins still driven in hold");
   hold_keep_a: assert property (!HOLD_GRANT_N && !AUXILIARY_CONTROL_HOLD_HIZ
      |-> $stable(ADDR_OUT) && ADDR_OE)
      else $error("address moved in hold");
   stretch_wait_a: assert property (stretch_held
      |=> !$rose(READ_STROBE_N) && !$rose(WRITE_STROBE_N))
      else $error("cycle ended while stretched");
   read_done_a: assert property ($rose(READ_STROBE_N) |-> RSP_VALID)
      else $error("read ended without answer");
   boot_frozen_a: assert property ($past(RST_B) |-> $stable(BOOT_MODE))
      else $error("boot mode moved");
endmodule
bind ebbc_ctrl ebbc_checker watch (.*);
`default_nettype wire

// File: verif/ebbc_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ebbc_mem
   import ebbc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic [BANKS-1:0] BANK_SELECT_N,
   input wire logic WRITE_STROBE_N,
   input wire logic READ_STROBE_N,
   input wire logic [DATA_W-1:0] DATA_OUT,
   input wire logic [3:0] stretch,
   output logic [DATA_W-1:0] DATA_IN,
   output logic CYCLE_STRETCH_N
);
   logic [DATA_W-1:0] mem [256];
   logic [DATA_W-1:0] last = '0;
   logic [3:0] cnt = '0;
   // released bus shows the inverse word so stale data never matches
   assign DATA_IN = READ_STROBE_N ? ~last : mem[BANK_SELECT_N];
   assign CYCLE_STRETCH_N = cnt >= stretch;
   // store writes, count strobe cycles for the stretch
   always @(posedge CLOCK)
   begin
      if (!WRITE_STROBE_N) mem[BANK_SELECT_N] <= DATA_OUT;
      if (!READ_STROBE_N) last <= DATA_IN;
      cnt <= (WRITE_STROBE_N && READ_STROBE_N) ? '0 : cnt + (cnt != 4'hf);
   end
endmodule
`default_nettype wire

// File: verif/ebbc_test.sv
`timescale 1ns/1ps
`default_nettype none
module ebbc_test
   import ebbc_pkg::*;
;
   logic CLOCK = 0, RST_B = 0, REQ_VALID = 0, REQ_WRITE = 0, AUXILIARY_CONTROL_HOLD_HIZ = 0;
   logic HOLD_REQUEST_N = 1, REQ_READY, RSP_VALID, BOOT_CAPTURED, ADDR_OE, WRITE_STROBE_N;
   logic READ_STROBE_N, CTRL_OE, HOLD_GRANT_N, CYCLE_STRETCH_N;
   logic [1:0] BOOT_STRAP_PINS = 0, BOOT_MODE;
   logic [31:0] REQ_ADDR = 0, REQ_WDATA = 0, RSP_RDATA, DATA_IN, DATA_OUT, DATA_OE, a, rd;
   logic [31:0] BANK_WAIT_CYCLES = 32'h10111111, pat = 32'ha5c3e18f;
   logic [39:0] BANK_SIZE_LOG2 = {{3{5'h1b}}, 5'h04, {4{5'h1b}}};
   logic [15:0] BANK_WIDTH = 16'haa8a;
   logic [ADDR_W-1:0] ADDR_OUT, ao;
   logic [7:0] BANK_SELECT_N, sel;
   logic [3:0] stretch = 0;
   logic [2:0] bk [4] = '{3'h2, 3'h3, 3'h6, 3'h3};
   int n_fail = 0, n_checks = 0, cyc = 0;
   ebbc_ctrl DUT (.*);
   ebbc_mem PEER (.*);
   always #5 CLOCK = ~CLOCK;
   task automatic chk(input string what, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rst(input logic [1:0] m);
      BOOT_STRAP_PINS = m;
      RST_B = 0;
      repeat (4) @(posedge CLOCK);
      #1 chk("captured", BOOT_CAPTURED, 0);
      RST_B = 1;
      BOOT_STRAP_PINS = ~m;
      repeat (4) @(posedge CLOCK);
      #1 chk("boot", BOOT_MODE, m);
      chk("captured", BOOT_CAPTURED, 1);
   endtask
   // request held until taken, selects gathered until the answer
   task automatic access(input logic we, input logic [31:0] ad, wd, output logic [31:0] q);
      REQ_VALID = 1;
      REQ_WRITE = we;
      REQ_ADDR = ad;
      REQ_WDATA = wd;
      for (int k = 0; k < 40 && !REQ_READY; k++) @(posedge CLOCK) #1;
      @(posedge CLOCK) #1;
      REQ_VALID = 0;
      sel = '1;
      ao = '1;
      for (int k = 0; k < 40 && !RSP_VALID; k++)
      begin
         sel = sel & BANK_SELECT_N;
         if (BANK_SELECT_N != 8'hff) ao = ADDR_OUT;
         @(posedge CLOCK) #1;
      end
      q = RSP_RDATA;
      chk("done", RSP_VALID, 1);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // every strap code, then traffic by width, wait count and stretch
   initial
   begin
      for (int m = 0; m < 4; m++) rst(m[1:0]);
      foreach (bk[i])
      begin
         a = {2'h0, bk[i], 27'h40};
         stretch = i == 3 ? 4'h6 : 4'h0;
         access(1'h1, a, pat ^ i, rd);
         chk("select", sel, 8'(~(8'h1 << bk[i])));
         chk("addr", ao, a[26:0]);
         access(1'h0, a, '0, rd);
         chk("read", rd, bk[i] == 3'h2 ? (pat ^ i) & 32'hff : pat ^ i);
      end
      access(1'h0, 32'h20000100, '0, rd);
      chk("unmapped", sel, 8'hff);
      // hold asked mid-access, both pin modes
      for (int h = 0; h < 2; h++)
      begin
         AUXILIARY_CONTROL_HOLD_HIZ = h[0];
         fork
            access(1'h0, 32'h30000040, '0, rd);
            #20 HOLD_REQUEST_N = 0;
         join
         for (int k = 0; k < 20 && HOLD_GRANT_N; k++) @(posedge CLOCK) #1;
         chk("grant", HOLD_GRANT_N, 0);
         chk("addr_oe", ADDR_OE, !h[0]);
         HOLD_REQUEST_N = 1;
         for (int k = 0; k < 20 && !HOLD_GRANT_N; k++) @(posedge CLOCK) #1;
         chk("release", HOLD_GRANT_N, 1);
      end
      complete_run();
   end
   // a hang counts as a mismatch
   always @(posedge CLOCK)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         complete_run();
      end
   end
endmodule
`default_nettype wire
